//--- shared/etc_pkg.sv
// Offsets, bit positions and reset values of the interrupt source block
package etc_pkg;
  // Register word indexes on the Avalon-MM slave (address bits 5:2)
  localparam logic [3:0] REG_RESET_CAUSE  = 4'h0;
  localparam logic [3:0] REG_MAIN_CTL     = 4'h1;
  localparam logic [3:0] REG_SECOND_CTL   = 4'h2;
  localparam logic [3:0] REG_THIRD_CTL    = 4'h3;
  localparam logic [3:0] REG_PIN_CHANGE   = 4'h4;
  localparam logic [3:0] REG_TIMER_LOW    = 4'h5;
  localparam logic [3:0] REG_TIMER_HIGH   = 4'h6;
  localparam logic [3:0] REG_TIMER_CTL    = 4'h7;

  // reset_cause_and_priority fields
  localparam int RC_PRIO_EN   = 7;
  localparam int RC_SOFT_BO   = 6;
  localparam int RC_RST_INSTR = 4;
  localparam int RC_WDT_EXP   = 3;
  localparam int RC_PWR_DOWN  = 2;
  localparam int RC_POWER_ON  = 1;
  localparam int RC_BROWNOUT  = 0;
  localparam logic [7:0] RC_RESET = 8'h5c;
  localparam logic [7:0] RC_SW_MASK = 8'hd3;

  // main_irq_control fields
  localparam int MC_GLOBAL_EN = 7;
  localparam int MC_PERIPH_EN = 6;
  localparam int MC_TIMER_EN  = 5;
  localparam int MC_EXT0_EN   = 4;
  localparam int MC_CHANGE_EN = 3;
  localparam int MC_TIMER_FLG = 2;
  localparam int MC_EXT0_FLG  = 1;
  localparam int MC_CHANGE_FLG = 0;

  // second_irq_control fields
  localparam int SC_EDGE0     = 6;
  localparam int SC_EDGE1     = 5;
  localparam int SC_EDGE2     = 4;
  localparam int SC_TIMER_PRI = 2;
  localparam int SC_CHANGE_PRI = 0;
  localparam logic [7:0] SC_RESET = 8'h75;

  // third_irq_control fields
  localparam int TC_EXT2_PRI  = 7;
  localparam int TC_EXT1_PRI  = 6;
  localparam int TC_EXT2_EN   = 4;
  localparam int TC_EXT1_EN   = 3;
  localparam int TC_EXT2_FLG  = 1;
  localparam int TC_EXT1_FLG  = 0;
  localparam logic [7:0] TC_RESET = 8'hc0;

  // Timer control: bit 0 selects the 16-bit count
  localparam int TM_WIDE      = 0;
  localparam logic [7:0] TIMER_ROLL = 8'hff;
endpackage

//--- verilog/etc_irq_logic.sv
// Interrupt sources, priority routing, wake-up and context capture
//
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Priority-enable bit set gives high and low levels; clear gives one level.
// - Each external pin edge select: 1 means rising edge, 0 falling edge.
// - A selected edge on an external pin sets that pin's flag.
// - An external pin request is suppressed while its enable bit is clear.
// - External interrupts wake the core only if enabled before it slept.
// - After such a wake, branch to the vector only with global enable set.
// - External one and two take priority from bits in the third control register.
// - External zero has no priority bit and is always high priority.
// - In 8-bit timer mode, rollover FF to 00 sets the overflow flag.
// - In 16-bit timer mode, rollover FFFF to 0000 sets the overflow flag.
// - Timer overflow gated by its enable, priority from second control register.
// - A level change on any upper-nibble port pin sets the change flag.
// - Only pins with change enable count; change enable bit gates the request.
// - Port change priority comes from its bit in the second control register.
// - On interrupt entry the return address is pushed on the return stack.
// - On entry working, status and bank registers are copied to the shadow.
// - Reset control register shows last reset or wake cause; two flags read-only.
// - Bit 5 of the reset control register always reads zero.
// - Single-level mode: peripheral sources need the peripheral enable bit too.
module etc_irq_logic #(
  parameter int PC_W = 21
) (
  input  wire logic            mclk,
  input  wire logic            rstn,
  input  wire logic [5:0]      avs_address,
  input  wire logic            avs_read,
  input  wire logic            avs_write,
  input  wire logic [31:0]     avs_writedata,
  input  wire logic [3:0]      avs_byteenable,
  output logic [31:0]          avs_readdata,
  output logic                 avs_waitrequest,
  input  wire logic [2:0]      ext_irq_pin,
  input  wire logic [3:0]      port_upper_pin,
  input  wire logic            timer_tick,
  input  wire logic            periph_irq,
  input  wire logic            periph_priority,
  input  wire logic            core_asleep,
  input  wire logic            sleep_enter,
  input  wire logic            wdt_expiry,
  input  wire logic            wdt_clear,
  input  wire logic            irq_entry,
  input  wire logic [PC_W-1:0] return_pc,
  input  wire logic [7:0]      working_register,
  input  wire logic [7:0]      status_register,
  input  wire logic [7:0]      bank_select_register,
  output logic                 irq_high,
  output logic                 irq_low,
  output logic                 wake_req,
  output logic                 wake_branch,
  output logic                 stack_push,
  output logic [PC_W-1:0]      stack_pc,
  output logic [7:0]           shadow_working,
  output logic [7:0]           shadow_status,
  output logic [7:0]           shadow_bank
);

  // Flag update: hardware set wins over a software clear in the same cycle
  function automatic logic flag_next(input logic cur, input logic wr, input logic wbit,
                                     input logic set);
    flag_next = (wr ? wbit : cur) | set;
  endfunction

  logic [7:0] reset_cause_and_priority;
  logic [7:0] main_irq_control;
  logic [7:0] second_irq_control;
  logic [7:0] third_irq_control;
  logic [3:0] per_pin_change_enable;
  logic [7:0] timer_zero_low_byte;
  logic [7:0] timer_zero_high_byte;
  logic       timer_wide;
  logic [6:0] sync_a;
  logic [6:0] sync_b;
  logic [6:0] sync_c;
  logic [2:0] sleep_enable_snap;

  // Bus decode
  logic       access;
  logic       wr_take;
  logic [3:0] reg_idx;
  logic [7:0] wbyte;
  logic       wr_lane;
  logic [7:0] read_byte;

  assign access  = avs_read | avs_write;
  assign wr_take = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign reg_idx = avs_address[5:2];
  assign wbyte   = avs_writedata[7:0];
  assign wr_lane = wr_take;

  function automatic logic wr_hit(input logic [3:0] idx, input logic [3:0] target,
                                  input logic take);
    wr_hit = take & (idx == target);
  endfunction

  logic wr_rc;
  logic wr_main;
  logic wr_second;
  logic wr_third;
  logic wr_change;
  logic wr_tlow;
  logic wr_thigh;
  logic wr_tctl;

  assign wr_rc     = wr_hit(reg_idx, etc_pkg::REG_RESET_CAUSE, wr_lane);
  assign wr_main   = wr_hit(reg_idx, etc_pkg::REG_MAIN_CTL, wr_lane);
  assign wr_second = wr_hit(reg_idx, etc_pkg::REG_SECOND_CTL, wr_lane);
  assign wr_third  = wr_hit(reg_idx, etc_pkg::REG_THIRD_CTL, wr_lane);
  assign wr_change = wr_hit(reg_idx, etc_pkg::REG_PIN_CHANGE, wr_lane);
  assign wr_tlow   = wr_hit(reg_idx, etc_pkg::REG_TIMER_LOW, wr_lane);
  assign wr_thigh  = wr_hit(reg_idx, etc_pkg::REG_TIMER_HIGH, wr_lane);
  assign wr_tctl   = wr_hit(reg_idx, etc_pkg::REG_TIMER_CTL, wr_lane);

  // One wait cycle per access; read data is valid when waitrequest drops
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
    end else if (access && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_comb begin
    case (reg_idx)
      etc_pkg::REG_RESET_CAUSE: read_byte = reset_cause_and_priority;
      etc_pkg::REG_MAIN_CTL:    read_byte = main_irq_control;
      etc_pkg::REG_SECOND_CTL:  read_byte = second_irq_control;
      etc_pkg::REG_THIRD_CTL:   read_byte = third_irq_control;
      etc_pkg::REG_PIN_CHANGE:  read_byte = {per_pin_change_enable, 4'h0};
      etc_pkg::REG_TIMER_LOW:   read_byte = timer_zero_low_byte;
      etc_pkg::REG_TIMER_HIGH:  read_byte = timer_zero_high_byte;
      etc_pkg::REG_TIMER_CTL:   read_byte = {7'h00, timer_wide};
      default:                  read_byte = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= {24'h00_0000, read_byte};
    end
  end

  // Three stages: first two synchronise, third gives the previous level
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sync_a <= 7'h00;
      sync_b <= 7'h00;
      sync_c <= 7'h00;
    end else begin
      sync_a <= {port_upper_pin, ext_irq_pin};
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  logic [2:0] edge_sel;
  logic [2:0] ext_edge;
  logic       change_seen;

  assign edge_sel = {second_irq_control[etc_pkg::SC_EDGE2],
                     second_irq_control[etc_pkg::SC_EDGE1],
                     second_irq_control[etc_pkg::SC_EDGE0]};
  assign ext_edge = (edge_sel & sync_b[2:0] & ~sync_c[2:0])
                  | (~edge_sel & ~sync_b[2:0] & sync_c[2:0]);
  assign change_seen = |((sync_b[6:3] ^ sync_c[6:3]) & per_pin_change_enable);

  // Timer zero counter
  logic timer_overflow;
  assign timer_overflow = timer_tick && (timer_zero_low_byte == etc_pkg::TIMER_ROLL)
                       && (!timer_wide || timer_zero_high_byte == etc_pkg::TIMER_ROLL)
                       && !wr_tlow && !wr_thigh;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      timer_zero_low_byte <= 8'h00;
    end else if (wr_tlow) begin
      timer_zero_low_byte <= wbyte;
    end else if (timer_tick) begin
      timer_zero_low_byte <= timer_zero_low_byte + 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      timer_zero_high_byte <= 8'h00;
    end else if (wr_thigh) begin
      timer_zero_high_byte <= wbyte;
    end else if (timer_tick && timer_wide && !wr_tlow
                 && timer_zero_low_byte == etc_pkg::TIMER_ROLL) begin
      timer_zero_high_byte <= timer_zero_high_byte + 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      timer_wide <= 1'b0;
    end else if (wr_tctl) begin
      timer_wide <= wbyte[etc_pkg::TM_WIDE];
    end
  end

  // Control registers with flags
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      main_irq_control <= 8'h00;
    end else begin
      if (wr_main) begin
        main_irq_control[7:3] <= wbyte[7:3];
      end
      main_irq_control[etc_pkg::MC_TIMER_FLG] <=
        flag_next(main_irq_control[etc_pkg::MC_TIMER_FLG], wr_main,
                  wbyte[etc_pkg::MC_TIMER_FLG], timer_overflow);
      main_irq_control[etc_pkg::MC_EXT0_FLG] <=
        flag_next(main_irq_control[etc_pkg::MC_EXT0_FLG], wr_main,
                  wbyte[etc_pkg::MC_EXT0_FLG], ext_edge[0]);
      main_irq_control[etc_pkg::MC_CHANGE_FLG] <=
        flag_next(main_irq_control[etc_pkg::MC_CHANGE_FLG], wr_main,
                  wbyte[etc_pkg::MC_CHANGE_FLG], change_seen);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      second_irq_control <= etc_pkg::SC_RESET;
    end else if (wr_second) begin
      second_irq_control <= wbyte;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      third_irq_control <= etc_pkg::TC_RESET;
    end else begin
      if (wr_third) begin
        third_irq_control[7:2] <= wbyte[7:2];
      end
      third_irq_control[etc_pkg::TC_EXT2_FLG] <=
        flag_next(third_irq_control[etc_pkg::TC_EXT2_FLG], wr_third,
                  wbyte[etc_pkg::TC_EXT2_FLG], ext_edge[2]);
      third_irq_control[etc_pkg::TC_EXT1_FLG] <=
        flag_next(third_irq_control[etc_pkg::TC_EXT1_FLG], wr_third,
                  wbyte[etc_pkg::TC_EXT1_FLG], ext_edge[1]);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      per_pin_change_enable <= 4'h0;
    end else if (wr_change) begin
      per_pin_change_enable <= wbyte[7:4];
    end
  end

  // Watchdog and power-down flags only move by hardware events
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reset_cause_and_priority <= etc_pkg::RC_RESET;
    end else begin
      if (wr_rc) begin
        reset_cause_and_priority <= (wbyte & etc_pkg::RC_SW_MASK)
                                  | (reset_cause_and_priority & ~etc_pkg::RC_SW_MASK);
      end
      if (wdt_clear) begin
        reset_cause_and_priority[etc_pkg::RC_WDT_EXP]  <= 1'b1;
        reset_cause_and_priority[etc_pkg::RC_PWR_DOWN] <= 1'b1;
      end else begin
        if (wdt_expiry) begin
          reset_cause_and_priority[etc_pkg::RC_WDT_EXP] <= 1'b0;
        end
        if (sleep_enter) begin
          reset_cause_and_priority[etc_pkg::RC_PWR_DOWN] <= 1'b0;
        end
      end
    end
  end

  // Request routing
  logic       prio_on;
  logic       global_en;
  logic       periph_en;
  logic [2:0] ext_flag;
  logic [2:0] ext_en;
  logic [2:0] ext_act;
  logic       timer_act;
  logic       change_act;
  logic       any_high;
  logic       any_low;
  logic       core_any;

  assign prio_on   = reset_cause_and_priority[etc_pkg::RC_PRIO_EN];
  assign global_en = main_irq_control[etc_pkg::MC_GLOBAL_EN];
  assign periph_en = main_irq_control[etc_pkg::MC_PERIPH_EN];
  assign ext_flag  = {third_irq_control[etc_pkg::TC_EXT2_FLG],
                      third_irq_control[etc_pkg::TC_EXT1_FLG],
                      main_irq_control[etc_pkg::MC_EXT0_FLG]};
  assign ext_en    = {third_irq_control[etc_pkg::TC_EXT2_EN],
                      third_irq_control[etc_pkg::TC_EXT1_EN],
                      main_irq_control[etc_pkg::MC_EXT0_EN]};
  assign ext_act   = ext_flag & ext_en;
  assign timer_act = main_irq_control[etc_pkg::MC_TIMER_FLG]
                   & main_irq_control[etc_pkg::MC_TIMER_EN];
  assign change_act = main_irq_control[etc_pkg::MC_CHANGE_FLG]
                    & main_irq_control[etc_pkg::MC_CHANGE_EN];
  assign core_any  = |ext_act | timer_act | change_act;

  assign any_high = ext_act[0]
                  | (ext_act[1] & third_irq_control[etc_pkg::TC_EXT1_PRI])
                  | (ext_act[2] & third_irq_control[etc_pkg::TC_EXT2_PRI])
                  | (timer_act & second_irq_control[etc_pkg::SC_TIMER_PRI])
                  | (change_act & second_irq_control[etc_pkg::SC_CHANGE_PRI])
                  | (periph_irq & periph_priority);
  assign any_low  = (ext_act[1] & ~third_irq_control[etc_pkg::TC_EXT1_PRI])
                  | (ext_act[2] & ~third_irq_control[etc_pkg::TC_EXT2_PRI])
                  | (timer_act & ~second_irq_control[etc_pkg::SC_TIMER_PRI])
                  | (change_act & ~second_irq_control[etc_pkg::SC_CHANGE_PRI])
                  | (periph_irq & ~periph_priority);

  // With priorities on, the peripheral enable bit acts as the low-level enable
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq_high <= 1'b0;
      irq_low  <= 1'b0;
    end else if (prio_on) begin
      irq_high <= global_en & any_high;
      irq_low  <= global_en & periph_en & any_low & ~any_high;
    end else begin
      irq_high <= global_en & (core_any | (periph_en & periph_irq));
      irq_low  <= 1'b0;
    end
  end

  // Enables are frozen while asleep so late enables cannot wake the core
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sleep_enable_snap <= 3'h0;
    end else if (!core_asleep) begin
      sleep_enable_snap <= ext_en;
    end
  end

  logic wake_now;
  assign wake_now = core_asleep & |(ext_flag & sleep_enable_snap);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wake_req    <= 1'b0;
      wake_branch <= 1'b0;
    end else begin
      wake_req    <= wake_now;
      wake_branch <= wake_now & global_en;
    end
  end

  // Context capture on entry; return address and shadow held until next entry
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stack_push <= 1'b0;
    end else begin
      stack_push <= irq_entry;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      stack_pc       <= '0;
      shadow_working <= 8'h00;
      shadow_status  <= 8'h00;
      shadow_bank    <= 8'h00;
    end else if (irq_entry) begin
      stack_pc       <= return_pc;
      shadow_working <= working_register;
      shadow_status  <= status_register;
      shadow_bank    <= bank_select_register;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence rise0_s;
    edge_sel[0] && sync_b[0] && !sync_c[0];
  endsequence
  sequence fall1_s;
    !edge_sel[1] && !sync_b[1] && sync_c[1];
  endsequence

  rising_edge_flag_a: assert property (rise0_s |=> ext_flag[0])
    else $error("rising edge did not set external zero flag");
  falling_edge_flag_a: assert property (fall1_s |=> ext_flag[1])
    else $error("falling edge did not set external one flag");
  ext_zero_high_a: assert property (prio_on && global_en && ext_act[0] |=> irq_high
                                    && !irq_low)
    else $error("external zero not routed as high priority");
  masked_ext_a: assert property (!core_asleep && !global_en |=> !irq_high && !irq_low)
    else $error("request raised with global enable clear");
  timer_byte_roll_a: assert property (timer_overflow && !timer_wide |=>
                                      main_irq_control[etc_pkg::MC_TIMER_FLG]
                                      && timer_zero_low_byte == 8'h00)
    else $error("8-bit rollover did not set overflow flag");
  timer_wide_roll_a: assert property (timer_overflow && timer_wide |=>
                                      main_irq_control[etc_pkg::MC_TIMER_FLG]
                                      && timer_zero_high_byte == 8'h00
                                      && timer_zero_low_byte == 8'h00)
    else $error("16-bit rollover did not set overflow flag");
  port_change_a: assert property (change_seen |=> main_irq_control[etc_pkg::MC_CHANGE_FLG])
    else $error("port change did not set change flag");
  single_level_a: assert property (!prio_on && !core_any && !periph_en |=> !irq_high
                                   && !irq_low)
    else $error("peripheral request passed without peripheral enable");
  context_save_a: assert property (irq_entry |=> stack_push && stack_pc == $past(return_pc)
                                   && shadow_working == $past(working_register))
    else $error("context not captured on entry");
  wake_branch_a: assert property (wake_now && !global_en |=> wake_req && !wake_branch)
    else $error("branch after wake without global enable");
  reserved_bit_a: assert property (!reset_cause_and_priority[5])
    else $error("reset control bit 5 not zero");
  bus_answer_a: assert property (access && avs_waitrequest |=> !avs_waitrequest ##1
                                 avs_waitrequest)
    else $error("bus answer not one cycle after request");

endmodule
`default_nettype wire

//--- testbench/etc_core_model.sv
// Behavioural core model that answers a pending request with an interrupt entry
`timescale 1ns/100ps
`default_nettype none
module etc_core_model (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        go,
  input  wire logic        irq_high,
  input  wire logic        irq_low,
  output logic             irq_entry,
  output logic [20:0]      return_pc,
  output logic [7:0]       working_register,
  output logic [7:0]       status_register,
  output logic [7:0]       bank_select_register
);
  logic [7:0] cnt;
  // Context changes every cycle, so a capture on the wrong edge cannot match
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 8'h00;
      irq_entry <= 1'b0;
    end else begin
      cnt <= cnt + 8'h01;
      irq_entry <= go && (irq_high || irq_low) && !irq_entry;
    end
  end
  assign return_pc = {5'h15, cnt, ~cnt};
  // Without the fast return path the handler must save these values itself
  assign working_register = cnt ^ 8'h5a;
  assign status_register = ~cnt;
  assign bank_select_register = {cnt[3:0], cnt[7:4]};
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking testbench of the interrupt source block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [2:0]  ext_irq_pin = 3'h0;
  logic [3:0]  port_upper_pin = 4'h0;
  logic        timer_tick = 1'b0, periph_irq = 1'b0, periph_priority = 1'b1;
  logic        core_asleep = 1'b0, sleep_enter = 1'b0, wdt_expiry = 1'b0;
  logic        wdt_clear = 1'b0, go = 1'b0, e;
  logic        irq_entry, irq_high, irq_low, wake_req, wake_branch, stack_push;
  logic [20:0] return_pc, stack_pc;
  logic [7:0]  working_register, status_register, bank_select_register, m;
  logic [7:0]  shadow_working, shadow_status, shadow_bank;
  logic [15:0] rd_q[$];
  logic [44:0] ctx_q[$];
  logic [15:0] rd_n;
  logic [44:0] ctx_n;
  int          err_count = 0, check_count = 0, seed = 32'h96b6, i, v;

  always #2 mclk = ~mclk;

  etc_irq_logic dut (.mclk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .ext_irq_pin, .port_upper_pin,
    .timer_tick, .periph_irq, .periph_priority, .core_asleep, .sleep_enter, .wdt_expiry,
    .wdt_clear, .irq_entry, .return_pc, .working_register, .status_register,
    .bank_select_register, .irq_high, .irq_low, .wake_req, .wake_branch, .stack_push,
    .stack_pc, .shadow_working, .shadow_status, .shadow_bank);
  etc_core_model core (.mclk, .rstn, .go, .irq_high, .irq_low, .irq_entry, .return_pc,
    .working_register, .status_register, .bank_select_register);

  task automatic chk(input string what, input logic [31:0] x, input logic [31:0] y);
    check_count++;
    if (y !== x) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, x, y);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Read expectations are queued; msk masks the bits that are compared
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] d,
                     input logic [7:0] msk);
    int n;
    @(posedge mclk);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    if (!wr) rd_q.push_back({msk, d & msk});
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    if (n >= 64) chk("waitrequest", 0, 1);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic route(input logic [7:0] rc, mn, sc, th, input logic h, l);
    bus(1, etc_pkg::REG_RESET_CAUSE, rc, 0);
    bus(1, etc_pkg::REG_MAIN_CTL, mn, 0);
    bus(1, etc_pkg::REG_SECOND_CTL, sc, 0);
    bus(1, etc_pkg::REG_THIRD_CTL, th, 0);
    idle(4);
    chk("irq_high", h, irq_high);
    chk("irq_low", l, irq_low);
  endtask
  task automatic tick();
    timer_tick <= 1'b1;
    idle(1);
    timer_tick <= 1'b0;
    idle(2);
  endtask
  task give_verdict();
    if (err_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge mclk) begin
    if (avs_read && avs_waitrequest === 1'b0 && rd_q.size() > 0) begin
      rd_n = rd_q.pop_front();
      chk("readdata", rd_n[7:0], avs_readdata[7:0] & rd_n[15:8]);
      chk("readdata_upper", 0, avs_readdata[31:8]);
    end
    if (irq_entry === 1'b1)
      ctx_q.push_back({return_pc, working_register, status_register, bank_select_register});
    if (stack_push === 1'b1 && ctx_q.size() > 0) begin
      ctx_n = ctx_q.pop_front();
      chk("stack_pc", ctx_n[44:24], stack_pc);
      chk("shadow", ctx_n[23:0], {shadow_working, shadow_status, shadow_bank});
    end
  end

  initial begin
    #40000;
    err_count++;
    give_verdict();
  end

  initial begin
    idle(20);
    rstn <= 1'b1;
    bus(0, etc_pkg::REG_RESET_CAUSE, 8'h5c, 8'hff);
    bus(0, etc_pkg::REG_SECOND_CTL, 8'h75, 8'hff);
    bus(0, etc_pkg::REG_THIRD_CTL, 8'hc0, 8'hff);
    bus(0, 4'h9, 8'h00, 8'hff);
    bus(1, etc_pkg::REG_RESET_CAUSE, 8'hff, 0);
    bus(0, etc_pkg::REG_RESET_CAUSE, 8'hdf, 8'hff);
    {sleep_enter, wdt_expiry} <= 2'b11;
    idle(1);
    {sleep_enter, wdt_expiry} <= 2'b00;
    bus(0, etc_pkg::REG_RESET_CAUSE, 8'h00, 8'h0c);
    wdt_clear <= 1'b1;
    idle(1);
    wdt_clear <= 1'b0;
    bus(0, etc_pkg::REG_RESET_CAUSE, 8'h0c, 8'h0c);
    avs_byteenable <= 4'h0;
    bus(1, etc_pkg::REG_MAIN_CTL, 8'hff, 0);
    avs_byteenable <= 4'hf;
    bus(0, etc_pkg::REG_MAIN_CTL, 8'h00, 8'hff);
    // Wrong edge first, then the selected edge, on each pin
    for (i = 0; i < 3; i++) begin
      e = 1'($random(seed));
      ext_irq_pin[i] <= e;
      idle(6);
      bus(1, etc_pkg::REG_SECOND_CTL, 8'h05 | ({7'h0, e} << (6 - i)), 0);
      bus(1, etc_pkg::REG_MAIN_CTL, 8'h00, 0);
      bus(1, etc_pkg::REG_THIRD_CTL, 8'h00, 0);
      m = (i == 0) ? 8'h02 : 8'h01 << (i - 1);
      for (v = 0; v < 2; v++) begin
        ext_irq_pin[i] <= (v == 1) ? e : !e;
        idle(6);
        bus(0, (i == 0) ? etc_pkg::REG_MAIN_CTL : etc_pkg::REG_THIRD_CTL, v ? m : 8'h00, m);
      end
    end
    route(8'h80, 8'hd2, 8'h00, 8'h00, 1, 0);
    route(8'h80, 8'hc0, 8'h00, 8'h09, 0, 1);
    route(8'h80, 8'hc0, 8'h00, 8'h49, 1, 0);
    route(8'h80, 8'hc0, 8'h00, 8'h41, 0, 0);
    route(8'h00, 8'h80, 8'h00, 8'h00, 0, 0);
    periph_irq <= 1'b1;
    idle(4);
    chk("request", 0, irq_high | irq_low);
    bus(1, etc_pkg::REG_MAIN_CTL, 8'hc0, 0);
    idle(4);
    chk("request", 1, irq_high | irq_low);
    periph_priority <= 1'b0;
    route(8'h80, 8'hc0, 8'h00, 8'h00, 0, 1);
    periph_priority <= 1'b1;
    periph_irq <= 1'b0;
    bus(1, etc_pkg::REG_TIMER_LOW, 8'hff, 0);
    tick();
    bus(0, etc_pkg::REG_MAIN_CTL, 8'h04, 8'h04);
    bus(0, etc_pkg::REG_TIMER_LOW, 8'h00, 8'hff);
    bus(1, etc_pkg::REG_MAIN_CTL, 8'h00, 0);
    bus(1, etc_pkg::REG_TIMER_CTL, 8'h01, 0);
    bus(1, etc_pkg::REG_TIMER_LOW, 8'hff, 0);
    bus(1, etc_pkg::REG_TIMER_HIGH, 8'hfe, 0);
    tick();
    bus(0, etc_pkg::REG_MAIN_CTL, 8'h00, 8'h04);
    bus(0, etc_pkg::REG_TIMER_HIGH, 8'hff, 8'hff);
    bus(1, etc_pkg::REG_TIMER_LOW, 8'hff, 0);
    tick();
    bus(0, etc_pkg::REG_MAIN_CTL, 8'h04, 8'h04);
    bus(0, etc_pkg::REG_TIMER_HIGH, 8'h00, 8'hff);
    route(8'h80, 8'ha4, 8'h04, 8'h00, 1, 0);
    route(8'h80, 8'h84, 8'h04, 8'h00, 0, 0);
    route(8'h80, 8'he4, 8'h00, 8'h00, 0, 1);
    // Only pin 5 may report a change
    bus(1, etc_pkg::REG_PIN_CHANGE, 8'h20, 0);
    bus(1, etc_pkg::REG_MAIN_CTL, 8'h00, 0);
    port_upper_pin <= 4'h1;
    idle(6);
    bus(0, etc_pkg::REG_MAIN_CTL, 8'h00, 8'h01);
    port_upper_pin <= 4'h3;
    idle(6);
    bus(0, etc_pkg::REG_MAIN_CTL, 8'h01, 8'h01);
    route(8'h80, 8'h89, 8'h01, 8'h00, 1, 0);
    route(8'h80, 8'h81, 8'h01, 8'h00, 0, 0);
    route(8'h80, 8'hc9, 8'h00, 8'h00, 0, 1);
    ext_irq_pin[0] <= 1'b0;
    idle(6);
    route(8'h00, 8'h10, 8'h40, 8'h00, 0, 0);
    core_asleep <= 1'b1;
    idle(2);
    ext_irq_pin[0] <= 1'b1;
    idle(6);
    chk("wake_req", 1, wake_req);
    chk("wake_branch", 0, wake_branch);
    bus(1, etc_pkg::REG_MAIN_CTL, 8'h92, 0);
    idle(3);
    chk("wake_branch", 1, wake_branch);
    core_asleep <= 1'b0;
    go <= 1'b1;
    idle(6);
    go <= 1'b0;
    idle(4);
    chk("pending_entries", 0, ctx_q.size());
    give_verdict();
  end
endmodule
`default_nettype wire
